// file: hw/tcc_prescaler.sv
// tcc_prescaler: count-clock enable for the timer core
// assumes: single clock mclk, synchronous active-low reset
`timescale 1ns/1ps
module tcc_prescaler (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        run,
  input  wire logic [tcc_pkg::PRESC_W-1:0] divSel,
  output logic                             tick
);

  // ==========================================================
  // divider, restarted while stopped so the first tick is aligned
  logic [tcc_pkg::PDIV_W-1:0] div_r;
  logic [tcc_pkg::PDIV_W-1:0] divMask;

  assign divMask = tcc_pkg::PDIV_W'((1 << divSel) - 1);
  assign tick    = run && ((div_r & divMask) == divMask);

  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

endmodule

// file: hw/tcc_timer.sv
// tcc_timer: 16-bit timer/event counter, two compare/capture registers
// assumes: classic wishbone slave on mclk; trigger input synchronous to mclk
//
// Behaviour
// - reset clears mode control register to zero
// - nonzero mode field runs counter, zero stops
// - mode register holds mode, clear, timing, overflow
// - trigger edge captures count to second in modes 01 and 10, clears in 10
// - count equals first register raises match, toggles
// - swapped roles: first captures, second compares
// - level pair set=1 reset=0 drives pin high
// - level pair set=0 reset=1 drives pin low
// - level pair zero keeps pin unchanged
// - output starts from preset level at start
// - mode values 01, 10, 11 all start
// - toggle mode inverts pin every match interrupt, except when a set or reset level write lands in that cycle
`timescale 1ns/1ps
module tcc_timer (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        captureTriggerInput,
  output logic             timerOutputPin,
  output logic             compareMatchIrq,
  output logic             irq
);

  // ==========================================================
  // state
  logic [1:0]               modeField_r;
  logic                     outTiming_r;
  logic                     ovf_r;
  logic                     swap_r;
  logic [1:0]               edgeSel_r;
  logic                     togEn_r;
  logic                     lvr_r;
  logic                     lvs_r;
  logic [tcc_pkg::PRESC_W-1:0] presc_r;
  logic [15:0]              first_r;
  logic [15:0]              second_r;
  logic [15:0]              count_r;
  logic [tcc_pkg::STS_W-1:0] sts_r;
  logic [tcc_pkg::STS_W-1:0] msk_r;
  logic                     trigPrev_r;
  logic                     pin_r;
  logic                     matchIrq_r;
  logic                     ack_r;
  logic [31:0]              datOut_r;

  // ==========================================================
  // bus decode
  logic        reqValid;
  logic        wrCommit;
  logic [31:0] byteMask;
  logic        hitMode;
  logic        hitCc;
  logic        hitOut;
  logic        hitPresc;
  logic        hitFirst;
  logic        hitSecond;
  logic        hitCount;
  logic        hitSts;
  logic        hitMsk;
  logic [31:0] readData;

  assign reqValid  = cyc_i && stb_i;
  // writes land on the edge where the master sees ack
  assign wrCommit  = reqValid && we_i && ack_r;
  assign byteMask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign hitMode   = adr_i == tcc_pkg::OFS_MODE;
  assign hitCc     = adr_i == tcc_pkg::OFS_CCCTL;
  assign hitOut    = adr_i == tcc_pkg::OFS_OUTCTL;
  assign hitPresc  = adr_i == tcc_pkg::OFS_PRESC;
  assign hitFirst  = adr_i == tcc_pkg::OFS_FIRST;
  assign hitSecond = adr_i == tcc_pkg::OFS_SECOND;
  assign hitCount  = adr_i == tcc_pkg::OFS_COUNT;
  assign hitSts    = adr_i == tcc_pkg::OFS_IRQSTS;
  assign hitMsk    = adr_i == tcc_pkg::OFS_IRQMSK;

  // merged write value, untouched lanes keep their old bits
  logic [31:0] modeOld;
  logic [31:0] ccOld;
  logic [31:0] outOld;
  logic [31:0] modeNew;
  logic [31:0] ccNew;
  logic [31:0] outNew;
  logic [31:0] firstNew;
  logic [31:0] secondNew;
  logic [31:0] mskNew;
  logic [31:0] w1c;

  assign modeOld   = {28'h0000000, modeField_r, outTiming_r, ovf_r};
  assign ccOld     = {29'h00000000, edgeSel_r, swap_r};
  assign outOld    = {29'h00000000, lvs_r, lvr_r, togEn_r};
  assign modeNew   = (modeOld & ~byteMask) | (dat_i & byteMask);
  assign ccNew     = (ccOld & ~byteMask) | (dat_i & byteMask);
  assign outNew    = (outOld & ~byteMask) | (dat_i & byteMask);
  assign firstNew  = ({16'h0000, first_r} & ~byteMask) | (dat_i & byteMask);
  assign secondNew = ({16'h0000, second_r} & ~byteMask) | (dat_i & byteMask);
  assign mskNew    = (32'(msk_r) & ~byteMask) | (dat_i & byteMask);
  assign w1c       = (wrCommit && hitSts) ? (dat_i & byteMask) : 32'h00000000;

  // unmapped addresses read zero and are still acknowledged
  assign readData =
    hitMode   ? modeOld :
    hitCc     ? ccOld :
    hitOut    ? outOld :
    hitPresc  ? 32'(presc_r) :
    hitFirst  ? {16'h0000, first_r} :
    hitSecond ? {16'h0000, second_r} :
    hitCount  ? {16'h0000, count_r} :
    hitSts    ? 32'(sts_r) :
    hitMsk    ? 32'(msk_r) : 32'h00000000;

  // ==========================================================
  // counting core
  logic        running;
  logic        tick;
  logic        trigRise;
  logic        trigFall;
  logic        trigEdge;
  logic        capEvt;
  logic        trigClear;
  logic [15:0] cmpVal;
  logic        matchPulse;
  logic        matchClear;
  logic        wrapEvt;
  logic        toggleEvt;
  logic        lvlWrite;
  logic [1:0]  lvlPair;

  assign running   = modeField_r != tcc_pkg::TCC_STOP;
  assign trigRise  = captureTriggerInput && !trigPrev_r;
  assign trigFall  = !captureTriggerInput && trigPrev_r;
  assign trigEdge  = running && (
    (edgeSel_r == tcc_pkg::TCC_EDGE_RISE && trigRise) ||
    (edgeSel_r == tcc_pkg::TCC_EDGE_FALL && trigFall) ||
    (edgeSel_r == tcc_pkg::TCC_EDGE_BOTH && (trigRise || trigFall)));
  assign capEvt    = trigEdge && (modeField_r == tcc_pkg::TCC_FREE ||
                                  modeField_r == tcc_pkg::TCC_TRIG_CLEAR);
  assign trigClear = trigEdge && modeField_r == tcc_pkg::TCC_TRIG_CLEAR;
  // compare role follows the swap bit; the other register captures
  assign cmpVal    = swap_r ? second_r : first_r;
  assign matchPulse = running && tick && count_r == cmpVal;
  assign matchClear = matchPulse && modeField_r == tcc_pkg::TCC_MATCH_CLEAR;
  assign wrapEvt   = running && tick && count_r == tcc_pkg::CNT_MAX &&
                     !trigClear && !matchClear;
  assign toggleEvt = (matchPulse && togEn_r) || (capEvt && outTiming_r);
  assign lvlWrite  = wrCommit && hitOut;
  assign lvlPair   = {outNew[tcc_pkg::OUT_LVS_BIT], outNew[tcc_pkg::OUT_LVR_BIT]};

  tcc_prescaler u_presc (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .run    (running),
    .divSel (presc_r),
    .tick   (tick)
  );

  // ==========================================================
  // control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      modeField_r <= tcc_pkg::MODE_RST[tcc_pkg::MODE_LSB +: 2];
      outTiming_r <= tcc_pkg::MODE_RST[tcc_pkg::MODE_TIM_BIT];
      ovf_r       <= tcc_pkg::MODE_RST[tcc_pkg::MODE_OVF_BIT];
      swap_r      <= 1'b0;
      edgeSel_r   <= 2'h0;
      togEn_r     <= 1'b0;
      lvr_r       <= 1'b0;
      lvs_r       <= 1'b0;
      presc_r     <= '0;
      msk_r       <= '0;
    end else begin
      // mode, clear condition, timing and overflow share one register
      if (wrCommit && hitMode) begin
        modeField_r <= modeNew[tcc_pkg::MODE_LSB +: 2];
        outTiming_r <= modeNew[tcc_pkg::MODE_TIM_BIT];
      end
      // a wrap in the clearing cycle still leaves the flag set
      ovf_r <= wrapEvt || ((wrCommit && hitMode) ? modeNew[tcc_pkg::MODE_OVF_BIT]
                                                 : ovf_r);
      if (wrCommit && hitCc) begin
        swap_r    <= ccNew[tcc_pkg::CC_SWAP_BIT];
        edgeSel_r <= ccNew[tcc_pkg::CC_EDGE_LSB +: 2];
      end
      if (lvlWrite) begin
        togEn_r <= outNew[tcc_pkg::OUT_TOGEN_BIT];
        lvr_r   <= outNew[tcc_pkg::OUT_LVR_BIT];
        lvs_r   <= outNew[tcc_pkg::OUT_LVS_BIT];
      end
      if (wrCommit && hitPresc) begin
        presc_r <= dat_i[tcc_pkg::PRESC_W-1:0] & byteMask[tcc_pkg::PRESC_W-1:0];
      end
      if (wrCommit && hitMsk) begin
        msk_r <= mskNew[tcc_pkg::STS_W-1:0];
      end
    end
  end

  // ==========================================================
  // counter and compare/capture registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_r    <= tcc_pkg::CNT_ZERO;
      first_r    <= tcc_pkg::CNT_ZERO;
      second_r   <= tcc_pkg::CNT_ZERO;
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= captureTriggerInput;
      if (trigClear || matchClear) begin
        count_r <= tcc_pkg::CNT_ZERO;
      end else if (running && tick) begin
        count_r <= count_r + 16'h0001;
      end
      // capture beats a software write in the same cycle
      if (capEvt && swap_r) begin
        first_r <= count_r;
      end else if (wrCommit && hitFirst) begin
        first_r <= firstNew[15:0];
      end
      if (capEvt && !swap_r) begin
        second_r <= count_r;
      end else if (wrCommit && hitSecond) begin
        second_r <= secondNew[15:0];
      end
    end
  end

  // ==========================================================
  // output pin; level stays across start so the preset shows first
  // level writes while running are not guarded, software must avoid them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_r      <= 1'b0;
      matchIrq_r <= 1'b0;
    end else begin
      matchIrq_r <= matchPulse;
      if (lvlWrite && lvlPair == tcc_pkg::LVL_SET) begin
        pin_r <= 1'b1;
      end else if (lvlWrite && lvlPair == tcc_pkg::LVL_RST) begin
        pin_r <= 1'b0;
      end else if (toggleEvt) begin // pair 00 keeps the level
        pin_r <= !pin_r;
      end
    end
  end

  // ==========================================================
  // interrupt status, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sts_r <= '0;
    end else begin
      sts_r <= (sts_r & ~w1c[tcc_pkg::STS_W-1:0]) | {capEvt, wrapEvt, matchPulse};
    end
  end

  // ==========================================================
  // wishbone answer: ack one cycle after the request, dropped next cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r    <= 1'b0;
      datOut_r <= 32'h00000000;
    end else begin
      ack_r <= reqValid && !ack_r;
      if (reqValid && !ack_r) begin
        datOut_r <= readData;
      end
    end
  end

  assign dat_o           = datOut_r;
  assign ack_o           = ack_r;
  assign timerOutputPin  = pin_r;
  assign compareMatchIrq = matchIrq_r;
  assign irq             = |(sts_r & msk_r);

  // ==========================================================
  // checks
  property p_reset_stop;
    @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> (modeField_r == tcc_pkg::TCC_STOP && !tick);
  endproperty
  a_reset_stop: assert property (p_reset_stop)
    else $error("mode field not zero after reset");

  property p_stop_hold;
    @(posedge mclk) disable iff (!rst_n)
      (!running && !(wrCommit && hitMode)) [*2] |-> $stable(count_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter moved while stopped");

  property p_count_up;
    @(posedge mclk) disable iff (!rst_n)
      (running && tick && !trigClear && !matchClear)
        |=> count_r == 16'($past(count_r) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not advance by one");

  property p_capture_clear;
    @(posedge mclk) disable iff (!rst_n)
      trigClear |=> (count_r == tcc_pkg::CNT_ZERO &&
                     (swap_r ? first_r : second_r) == $past(count_r));
  endproperty
  a_capture_clear: assert property (p_capture_clear)
    else $error("capture or clear missing on trigger edge");

  property p_match_toggle;
    @(posedge mclk) disable iff (!rst_n)
      (matchPulse && togEn_r && !lvlWrite) |=> (pin_r != $past(pin_r)) && compareMatchIrq;
  endproperty
  a_match_toggle: assert property (p_match_toggle)
    else $error("match did not toggle pin or raise interrupt");

  property p_level_high;
    @(posedge mclk) disable iff (!rst_n)
      (lvlWrite && lvlPair == tcc_pkg::LVL_SET) |=> timerOutputPin;
  endproperty
  a_level_high: assert property (p_level_high)
    else $error("set level did not drive pin high");

  property p_level_low;
    @(posedge mclk) disable iff (!rst_n)
      (lvlWrite && lvlPair == tcc_pkg::LVL_RST) |=> !timerOutputPin;
  endproperty
  a_level_low: assert property (p_level_low)
    else $error("reset level did not drive pin low");

  property p_level_keep;
    @(posedge mclk) disable iff (!rst_n)
      (lvlWrite && lvlPair == tcc_pkg::LVL_KEEP && !toggleEvt) |=> $stable(timerOutputPin);
  endproperty
  a_level_keep: assert property (p_level_keep)
    else $error("pin changed on cleared level bits");

  property p_overflow;
    @(posedge mclk) disable iff (!rst_n)
      wrapEvt |=> (ovf_r && count_r == tcc_pkg::CNT_ZERO && sts_r[tcc_pkg::STS_OVF]);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("wrap without overflow flag");

  property p_start;
    @(posedge mclk) disable iff (!rst_n)
      $rose(running) |-> ##[0:8] tick;
  endproperty
  a_start: assert property (p_start)
    else $error("timer did not start counting");

endmodule

// file: inc/tcc_pkg.sv
// tcc_pkg: register map, field positions, reset values and mode encodings
// assumes: shared by the 16-bit timer core and its prescaler
package tcc_pkg;

  // ==========================================================
  // register map, byte addresses on a 32-bit wishbone port
  localparam int         ADR_W      = 8;
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CCCTL  = 8'h04;
  localparam logic [7:0] OFS_OUTCTL = 8'h08;
  localparam logic [7:0] OFS_PRESC  = 8'h0c;
  localparam logic [7:0] OFS_FIRST  = 8'h10;
  localparam logic [7:0] OFS_SECOND = 8'h14;
  localparam logic [7:0] OFS_COUNT  = 8'h18;
  localparam logic [7:0] OFS_IRQSTS = 8'h1c;
  localparam logic [7:0] OFS_IRQMSK = 8'h20;

  // ==========================================================
  // field positions
  localparam int MODE_OVF_BIT  = 0;
  localparam int MODE_TIM_BIT  = 1;
  localparam int MODE_LSB      = 2;
  localparam int CC_SWAP_BIT   = 0;
  localparam int CC_EDGE_LSB   = 1;
  localparam int OUT_TOGEN_BIT = 0;
  localparam int OUT_LVR_BIT   = 1;
  localparam int OUT_LVS_BIT   = 2;
  localparam int STS_MATCH     = 0;
  localparam int STS_OVF       = 1;
  localparam int STS_CAP       = 2;
  localparam int STS_W         = 3;
  localparam int PRESC_W       = 2;
  localparam int PDIV_W        = 3;

  // ==========================================================
  // reset values and count limits
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    TCC_STOP, TCC_FREE, TCC_TRIG_CLEAR, TCC_MATCH_CLEAR
  } tcc_mode_t;

  typedef enum logic [1:0] {
    TCC_EDGE_FALL, TCC_EDGE_RISE, TCC_EDGE_BOTH, TCC_EDGE_NONE
  } tcc_edge_t;

  localparam logic [1:0] LVL_SET  = 2'h2;
  localparam logic [1:0] LVL_RST  = 2'h1;
  localparam logic [1:0] LVL_KEEP = 2'h0;

endpackage

// file: tb/tcc_trig_model.sv
// tcc_trig_model: trigger source and load on the timer output pin
// assumes: driven on mclk; fire is a one-cycle request from the bench
`timescale 1ns/1ps
module tcc_trig_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        fire,
  input  wire logic        pinLevel,
  output logic             trigOut,
  output logic [15:0]      pinEdges
);
  // ==========================================================
  // trigger pulse, held 4 cycles so one rising edge is clean
  logic [1:0] holdCnt;
  logic       lastPin;
  initial begin
    trigOut  = 1'b0;
    holdCnt  = 2'h0;
    pinEdges = 16'h0000;
    lastPin  = 1'b0;
  end
  always @(posedge mclk) begin
    if (!rst_n) begin
      trigOut  <= 1'b0;
      holdCnt  <= 2'h0;
      pinEdges <= 16'h0000;
    end else begin
      if (fire) begin
        trigOut <= 1'b1;
        holdCnt <= 2'h3;
      end else if (holdCnt != 2'h0) begin
        holdCnt <= holdCnt - 2'h1;
      end else begin
        trigOut <= 1'b0;
      end
      // load side: count every change of the pin level
      if (pinLevel !== lastPin) begin
        pinEdges <= pinEdges + 16'h0001;
      end
    end
    lastPin <= pinLevel;
  end
endmodule

// file: tb/testbench.sv
// testbench: self-checking bench for the 16-bit timer block
// assumes: tcc_pkg compiled first; one clock, bench is wishbone master
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin errCount++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  // ==========================================================
  // signals
  logic        mclk  = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic        fire  = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        pin;
  logic        cmi;
  logic        irq;
  logic        trig;
  logic [15:0] pinEdges;
  logic [31:0] q;
  logic [31:0] c0;
  int          errCount = 0;
  int          nTests   = 0;

  tcc_timer u_dut (.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .captureTriggerInput(trig), .timerOutputPin(pin), .compareMatchIrq(cmi), .irq(irq));
  tcc_trig_model u_model (.mclk(mclk), .rst_n(rst_n), .fire(fire), .pinLevel(pin),
    .trigOut(trig), .pinEdges(pinEdges));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // bus and helpers; every task starts and ends just after an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    // no local limit: only the hang guard ends a missing answer
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat;
    `CHK("bus ack", 1'b1, ack)
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic doReset();
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic pulseFire();
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic waitMatch();
    int n;
    n = 0;
    while (cmi !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    `CHK("match pulse", 1'b1, cmi)
    @(posedge mclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic tReset();
    doReset();
    rd(tcc_pkg::OFS_MODE);
    `CHK("mode after reset", 32'h0, q)
    rd(tcc_pkg::OFS_COUNT);
    c0 = q;
    rd(tcc_pkg::OFS_COUNT);
    `CHK("stopped count", c0, q)
    `CHK("pin after reset", 1'b0, pin)
    rd(8'hfc);
    `CHK("unmapped read", 32'h0, q)
  endtask
  task automatic tLevels();
    wr(tcc_pkg::OFS_OUTCTL, 32'h4);
    `CHK("level set", 1'b1, pin)
    wr(tcc_pkg::OFS_OUTCTL, 32'h0);
    `CHK("level keep high", 1'b1, pin)
    wr(tcc_pkg::OFS_OUTCTL, 32'h2);
    `CHK("level reset", 1'b0, pin)
    wr(tcc_pkg::OFS_OUTCTL, 32'h0);
    `CHK("level keep low", 1'b0, pin)
  endtask
  task automatic tModes();
    wr(tcc_pkg::OFS_FIRST, 32'hffff);
    for (int m = 1; m < 4; m++) begin
      wr(tcc_pkg::OFS_MODE, 32'(m) << 2);
      rd(tcc_pkg::OFS_COUNT);
      c0 = q;
      rd(tcc_pkg::OFS_COUNT);
      `CHK("count advance", c0 + 32'h3, q)
      wr(tcc_pkg::OFS_MODE, 32'h0);
      rd(tcc_pkg::OFS_COUNT);
      c0 = q;
      rd(tcc_pkg::OFS_COUNT);
      `CHK("count held", c0, q)
    end
  endtask
  task automatic tOverflow();
    int n;
    n = 0;
    wr(tcc_pkg::OFS_IRQSTS, 32'h7);
    wr(tcc_pkg::OFS_IRQMSK, 32'h2);
    wr(tcc_pkg::OFS_MODE, 32'h4);
    // a full wrap is 65536 ticks; the bound leaves margin
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge mclk);
      n++;
    end
    `CHK("overflow irq", 1'b1, irq)
    rd(tcc_pkg::OFS_MODE);
    `CHK("overflow flag", 1'b1, q[0])
    wr(tcc_pkg::OFS_MODE, 32'h0);
    rd(tcc_pkg::OFS_IRQSTS);
    `CHK("overflow status", 1'b1, q[1])
    wr(tcc_pkg::OFS_IRQMSK, 32'h0);
    `CHK("masked irq", 1'b0, irq)
    wr(tcc_pkg::OFS_IRQSTS, 32'h2);
    rd(tcc_pkg::OFS_IRQSTS);
    `CHK("status cleared", 1'b0, q[1])
  endtask
  task automatic tCapture();
    doReset();
    wr(tcc_pkg::OFS_FIRST, 32'h40);
    wr(tcc_pkg::OFS_CCCTL, 32'h2);
    wr(tcc_pkg::OFS_OUTCTL, 32'h4);
    wr(tcc_pkg::OFS_OUTCTL, 32'h1);
    wr(tcc_pkg::OFS_MODE, 32'h8);
    `CHK("preset at start", 1'b1, pin)
    rd(tcc_pkg::OFS_COUNT);
    c0 = q;
    pulseFire();
    rd(tcc_pkg::OFS_COUNT);
    `CHK("count cleared", 1'b1, q < 32'h10)
    rd(tcc_pkg::OFS_SECOND);
    `CHK("captured", 1'b1, q > c0 && q < c0 + 32'h14)
    waitMatch();
    `CHK("pin toggled", 1'b0, pin)
    `CHK("load edges", 16'h0002, pinEdges)
    rd(tcc_pkg::OFS_IRQSTS);
    `CHK("match and capture status", 3'h5, q[2:0] & 3'h5)
  endtask
  task automatic tSwap();
    wr(tcc_pkg::OFS_MODE, 32'h0);
    wr(tcc_pkg::OFS_IRQSTS, 32'h7);
    wr(tcc_pkg::OFS_CCCTL, 32'h3);
    wr(tcc_pkg::OFS_SECOND, 32'h40);
    wr(tcc_pkg::OFS_MODE, 32'h8);
    rd(tcc_pkg::OFS_COUNT);
    c0 = q;
    pulseFire();
    rd(tcc_pkg::OFS_FIRST);
    `CHK("swap captured", 1'b1, q > c0 && q < c0 + 32'h14)
    waitMatch();
    `CHK("swap pin toggled", 1'b1, pin)
    rd(tcc_pkg::OFS_IRQSTS);
    `CHK("swap status", 3'h5, q[2:0] & 3'h5)
    wr(tcc_pkg::OFS_MODE, 32'h0);
  endtask

  // free run with capture toggles on both edges, divided clock, match clear
  task automatic tMore();
    wr(tcc_pkg::OFS_CCCTL, 32'h4);
    wr(tcc_pkg::OFS_OUTCTL, 32'h2);
    wr(tcc_pkg::OFS_OUTCTL, 32'h0);
    wr(tcc_pkg::OFS_PRESC, 32'h2);
    wr(tcc_pkg::OFS_MODE, 32'h6);
    rd(tcc_pkg::OFS_COUNT);
    c0 = q;
    @(posedge mclk);
    rd(tcc_pkg::OFS_COUNT);
    `CHK("divided count", c0 + 32'h1, q)
    c0 = 32'(pinEdges);
    pulseFire();
    rd(tcc_pkg::OFS_SECOND);
    `CHK("two capture toggles", c0 + 32'h2, 32'(pinEdges))
    `CHK("pin after both edges", 1'b0, pin)
    c0 = q;
    rd(tcc_pkg::OFS_COUNT);
    `CHK("free run keeps count", 1'b1, q >= c0 && c0 != 32'h0)
    rd(tcc_pkg::OFS_IRQSTS);
    `CHK("free run capture status", 1'b1, q[2])
    wr(tcc_pkg::OFS_MODE, 32'h0);
    wr(tcc_pkg::OFS_PRESC, 32'h0);
    rd(tcc_pkg::OFS_COUNT);
    wr(tcc_pkg::OFS_FIRST, q + 32'h8);
    wr(tcc_pkg::OFS_MODE, 32'hc);
    waitMatch();
    rd(tcc_pkg::OFS_COUNT);
    `CHK("match clears count", 1'b1, q < 32'h8)
    wr(tcc_pkg::OFS_MODE, 32'h0);
  endtask

  // ==========================================================
  // verdict
  task automatic wrapUp();
    $display("checks %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    tReset();
    tLevels();
    tModes();
    tOverflow();
    tCapture();
    tSwap();
    tMore();
    wrapUp();
  end

  // hang guard: the run needs about 66000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    errCount++;
    wrapUp();
  end
endmodule
